// file: laser_remote_port.sv
/*
 * Hardwired remote control port of a laser source: samples the
 * controller's discrete lines, runs the program handshake and drives the
 * registered status lines; a Wishbone slave lets firmware feed the laser
 * conditions in and read the port state out.
 * Assumes one 40 MHz clock and a synchronous active-high reset.
 */
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
// What this block does
// [R1] Ignore all inputs until remote request asserted.
// [R2] No program selected: start is emission enable.
// [R3] Program selected: start rising edge runs program.
// [R4] Controller holds start high while program runs.
// [R5] Power source: program, else analog if enabled.
// [R6] Internal-control enable hands control to software.
// [R7] Alarm reset rising edge clears alarm; 1ms.
// [R8] Guide light on while guide request high.
// [R9] Analog enable works only with program zero.
// [R10] Program stop high aborts running program immediately.
// [R11] Program number: seven select bits, first LSB.
// [R12] Sync input releases program wait instruction.
// [R13] Main power on rising, off falling edge.
// [R14] Gate select codes one to three open channels; zero closes.
// [R15] Ready high when prepared to emit.
// [R16] Emitting high while light is produced.
// [R17] Internal-mode output high under internal control.
// [R18] Fault output high in abnormal condition.
// [R19] Guide status high while guide light emitted.
// [R20] Analog-mode output high under analog power control.
// [R21] Acknowledge high once remote request accepted.
// [R22] Program ended set on completion, cleared by start.
// [R23] Abnormal end set on failure, cleared by reset.
// [R24] Warning output high in warning condition.
// [R25] Gate status reports open channel, same codes.
// [R26] Two-flop synchronise inputs, edges from synced samples.
// [R27] Reset clears outputs and idles programming.
`timescale 1ns/1ps
`default_nettype none

module laser_remote_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Hardwired port
    input wire laser_port_pkg::hw_in_t pins_in,
    output var laser_port_pkg::hw_out_t pins_out,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import laser_port_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic gate_code_ok(input logic [3:0] code);
        gate_code_ok = (code <= GATE_LAST);
    endfunction

    function automatic logic [2:0] gate_onehot(input logic [3:0] code);
        logic [2:0] v;
        v = 3'h0;
        if (code != GATE_CLOSED && gate_code_ok(code))
        begin
            v[code[1:0] - 2'h1] = 1'b1;
        end
        gate_onehot = v;
    endfunction

    // ------------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------------
    hw_in_t lvl;
    hw_in_t rise;
    hw_in_t fall;

    pin_sync #(.W($bits(hw_in_t))) u_sync ( // [R26]
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(pins_in),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    // Nothing but the request itself is seen while the request is low.
    wire logic req = lvl.remote_request_in;
    hw_in_t acc;
    hw_in_t acc_rise;
    hw_in_t acc_fall;
    assign acc = req ? lvl : '0; // [R1]
    assign acc_rise = req ? rise : '0; // [R1]
    assign acc_fall = req ? fall : '0; // [R1]

    wire logic [6:0] prog_num = acc.program_select_in; // [R11]
    wire logic prog_mode = (prog_num != PROG_NONE); // [R3]
    wire logic analog_sel = acc.analog_enable_in && !prog_mode; // [R9]
    wire logic int_mode = acc.internal_control_enable_in; // [R6]

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic [3:0] ctrl;
    wire logic wb_req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master sees the acknowledge.
    wire logic wr_fire = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    wire logic hit_ctrl = (wb_adr_i == ADR_CTRL);
    wire logic hit_cmd = (wb_adr_i == ADR_CMD);
    wire logic hit_status = (wb_adr_i == ADR_STATUS);
    wire logic hit_prog = (wb_adr_i == ADR_PROG);
    wire logic cmd_wr = wr_fire && hit_cmd;
    wire logic cmd_done = cmd_wr && wb_dat_i[CMD_DONE];
    wire logic cmd_fail = cmd_wr && wb_dat_i[CMD_FAIL];
    wire logic cmd_wait = cmd_wr && wb_dat_i[CMD_WAIT];

    // ------------------------------------------------------------------
    // Laser state
    // ------------------------------------------------------------------
    prog_state_t state;
    prog_state_t next_state;
    logic alarm;
    logic power_on;
    logic ended;
    logic abnormal;
    logic [3:0] gate;
    power_src_t power_src;

    wire logic running = (state != PS_IDLE);
    wire logic ready_now = power_on && !alarm && ctrl[CTRL_LASER_OK];
    // Losing the request or the program number also ends the program.
    wire logic abort = running && (acc.program_stop_in || !prog_mode
        || !ready_now); // [R10]
    wire logic start_ok = prog_mode && acc_rise.start_execute_in
        && ready_now && !int_mode; // [R3]

    always_comb
    begin
        next_state = state;
        case (state)
            PS_IDLE:
                if (start_ok)
                    next_state = PS_RUN; // [R3]
            PS_RUN:
                if (abort || cmd_done || cmd_fail)
                    next_state = PS_IDLE; // [R10]
                else if (cmd_wait)
                    next_state = PS_HOLD;
            PS_HOLD:
                if (abort)
                    next_state = PS_IDLE; // [R10]
                else if (acc_rise.sync_in)
                    next_state = PS_RUN; // [R12]
            default:
                next_state = PS_IDLE;
        endcase
    end

    // The controller keeps start high while running, so a done never
    // meets the start-low clear in the same cycle.
    wire logic set_ended = (state == PS_RUN) && cmd_done && !abort; // [R4]
    wire logic next_ended = set_ended
        || (ended && acc.start_execute_in); // [R22]
    wire logic set_abn = (running && abort)
        || (state == PS_RUN && cmd_fail);
    wire logic next_abn = set_abn
        || (abnormal && !acc.alarm_reset_in); // [R23]
    // A fault held by firmware survives a reset pulse on purpose.
    wire logic next_alarm = ctrl[CTRL_FAULT]
        || (alarm && !acc_rise.alarm_reset_in); // [R7]
    wire logic next_power = acc_rise.main_power_in ? 1'b1 :
        acc_fall.main_power_in ? 1'b0 : power_on; // [R13]
    wire logic gate_load = req && gate_code_ok(acc.gate_select_in);
    wire logic [3:0] next_gate = gate_load ? acc.gate_select_in
        : gate; // [R14]
    wire logic plain_emit = !prog_mode && acc.start_execute_in; // [R2]
    wire logic emit_req = int_mode ? ctrl[CTRL_PC_EMIT] :
        (plain_emit || next_state == PS_RUN);
    wire logic emit_now = ready_now && emit_req; // [R16]
    wire power_src_t next_src = prog_mode ? PWR_PROGRAM :
        analog_sel ? PWR_ANALOG : PWR_NONE; // [R5]

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state <= PS_IDLE; // [R27]
            alarm <= 1'b0;
            power_on <= 1'b0;
            ended <= 1'b0;
            abnormal <= 1'b0;
            gate <= GATE_CLOSED;
            power_src <= PWR_NONE;
        end
        else
        begin
            state <= next_state;
            alarm <= next_alarm;
            power_on <= next_power;
            ended <= next_ended;
            abnormal <= next_abn;
            gate <= next_gate;
            power_src <= next_src;
        end
    end

    // ------------------------------------------------------------------
    // Status lines
    // ------------------------------------------------------------------
    hw_out_t next_out;

    always_comb
    begin
        next_out = '0;
        next_out.ready_out = ready_now; // [R15]
        next_out.emitting_out = emit_now; // [R16]
        next_out.internal_mode_out = int_mode; // [R17]
        next_out.fault_out = next_alarm; // [R18]
        next_out.guide_light_out = acc.guide_light_request_in; // [R8] [R19]
        next_out.analog_mode_out = analog_sel; // [R20]
        next_out.request_ack_out = req; // [R21]
        next_out.main_power_on_out = next_power;
        next_out.program_running_out = (next_state != PS_IDLE);
        next_out.program_ended_out = next_ended; // [R22]
        next_out.abnormal_end_out = next_abn; // [R23]
        next_out.warning_out = ctrl[CTRL_WARN]; // [R24]
        next_out.gate_status_out = next_gate; // [R25]
        next_out.gate_open_out = gate_onehot(next_gate); // [R14]
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pins_out <= '0; // [R27]
        else
            pins_out <= next_out;
    end

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    wire logic [31:0] rd_ctrl = {28'h0, ctrl};
    wire logic [31:0] rd_status = {11'h0, pins_out, state};
    wire logic [31:0] rd_prog = {19'h0, power_src, gate, prog_num};
    wire logic [31:0] rd_mux = hit_ctrl ? rd_ctrl :
        hit_status ? rd_status :
        hit_prog ? rd_prog : 32'h0;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl <= CTRL_RESET;
        end
        else
        begin
            wb_ack_o <= wb_req && !wb_ack_o;
            if (wb_req && !wb_ack_o)
                wb_dat_o <= rd_mux;
            if (wr_fire && hit_ctrl)
                ctrl <= wb_dat_i[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_start;
        state == PS_IDLE && start_ok;
    endsequence

    sequence s_wait_release;
        state == PS_HOLD && acc_rise.sync_in && !abort;
    endsequence

    a_ack_tracks_req: assert property ( // [R21]
        $rose(req) |=> pins_out.request_ack_out)
        else $error("acknowledge did not follow the request");
    a_idle_no_req: assert property ( // [R1]
        !req |=> !pins_out.emitting_out && !pins_out.guide_light_out
            && !pins_out.program_running_out)
        else $error("port acted without a request");
    a_plain_enable: assert property ( // [R2]
        req && !prog_mode && !int_mode && ready_now
            && acc.start_execute_in |=> pins_out.emitting_out)
        else $error("start did not act as emission enable");
    a_prog_start: assert property ( // [R3]
        s_start |=> pins_out.program_running_out ##0 state == PS_RUN)
        else $error("program did not start on start edge");
    a_stop_aborts: assert property ( // [R10]
        running && acc.program_stop_in |=> !pins_out.program_running_out
            ##0 pins_out.abnormal_end_out)
        else $error("program stop did not abort");
    a_wait_release: assert property ( // [R12]
        s_wait_release |=> state == PS_RUN)
        else $error("sync did not release wait");
    a_main_power: assert property ( // [R13]
        acc_rise.main_power_in |=> pins_out.main_power_on_out)
        else $error("main power did not switch on");
    a_power_off: assert property ( // [R13]
        acc_fall.main_power_in |=> !pins_out.main_power_on_out)
        else $error("main power did not switch off");
    a_pc_emission: assert property ( // [R6]
        int_mode && ready_now && ctrl[CTRL_PC_EMIT]
            |=> pins_out.emitting_out)
        else $error("software emission not followed");
    a_fail_aborts: assert property ( // [R23]
        state == PS_RUN && cmd_fail |=> !pins_out.program_running_out
            ##0 pins_out.abnormal_end_out)
        else $error("program failure not reported");
    a_abn_clear: assert property ( // [R23]
        !running && acc.alarm_reset_in |=> !pins_out.abnormal_end_out)
        else $error("abnormal end not cleared by reset");
    a_guide_light: assert property ( // [R8]
        acc.guide_light_request_in |=> pins_out.guide_light_out)
        else $error("guide light did not follow request");
    a_internal_out: assert property ( // [R17]
        int_mode |=> pins_out.internal_mode_out)
        else $error("internal mode not reported");
    a_gate_decode: assert property ( // [R14]
        req && gate_code_ok(acc.gate_select_in)
            |=> pins_out.gate_status_out == $past(acc.gate_select_in))
        else $error("gate status mismatch");
    a_ended_clear: assert property ( // [R22]
        ended && !acc.start_execute_in && !set_ended
            |=> !pins_out.program_ended_out)
        else $error("program ended not cleared");
    a_alarm_clear: assert property ( // [R7]
        acc_rise.alarm_reset_in && !ctrl[CTRL_FAULT] |=> !pins_out.fault_out)
        else $error("alarm not cleared by reset edge");
    a_analog_mode: assert property ( // [R9]
        prog_mode |=> !pins_out.analog_mode_out)
        else $error("analog mode with program selected");

endmodule

`default_nettype wire

// file: laser_port_pkg.sv
/*
 * Shared types and constants of the hardwired remote control port: pin
 * bundles, program states, power sources and the Wishbone register map.
 * Assumes a single 40 MHz clock domain for all users of the package.
 */
`default_nettype none

package laser_port_pkg;

    // ------------------------------------------------------------------
    // Pin bundles
    // ------------------------------------------------------------------
    typedef struct packed {
        logic remote_request_in;
        logic start_execute_in;
        logic internal_control_enable_in;
        logic alarm_reset_in;
        logic guide_light_request_in;
        logic analog_enable_in;
        logic program_stop_in;
        logic [6:0] program_select_in;
        logic sync_in;
        logic main_power_in;
        logic [3:0] gate_select_in;
    } hw_in_t;

    typedef struct packed {
        logic ready_out;
        logic emitting_out;
        logic internal_mode_out;
        logic fault_out;
        logic guide_light_out;
        logic analog_mode_out;
        logic request_ack_out;
        logic main_power_on_out;
        logic program_running_out;
        logic program_ended_out;
        logic abnormal_end_out;
        logic warning_out;
        logic [3:0] gate_status_out;
        logic [2:0] gate_open_out;
    } hw_out_t;

    // ------------------------------------------------------------------
    // States and modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PS_IDLE, PS_RUN, PS_HOLD} prog_state_t;
    typedef enum logic [1:0] {PWR_NONE, PWR_PROGRAM, PWR_ANALOG} power_src_t;

    localparam logic [6:0] PROG_NONE = 7'h00;
    localparam logic [3:0] GATE_CLOSED = 4'h0;
    localparam logic [3:0] GATE_LAST = 4'h3;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_PROG = 8'h0c;

    localparam int CTRL_LASER_OK = 0;
    localparam int CTRL_FAULT = 1;
    localparam int CTRL_WARN = 2;
    localparam int CTRL_PC_EMIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    localparam int CMD_DONE = 0;
    localparam int CMD_FAIL = 1;
    localparam int CMD_WAIT = 2;

endpackage

`default_nettype wire

// file: pin_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin inputs, with rising and
 * falling edge pulses taken from the synchronised samples only.
 * Assumes the pins are asynchronous to ref_clk and change slowly.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Pins and synchronised view
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] meta;
    logic [W-1:0] prev;

    // The first stage feeds only the second; edges use later stages.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta <= '0;
            level <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= async_in;
            level <= meta;
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule

`default_nettype wire

// file: plc_model.sv
/*
 * Behavioural model of the machine controller that drives the port lines.
 * Assumes the bench hands it the wanted line levels on every clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module plc_model #(
    parameter int HOLD = 40000
) (
    // Clock
    input wire logic ref_clk,
    // Port status and wanted lines
    input wire laser_port_pkg::hw_out_t status,
    input wire laser_port_pkg::hw_in_t want,
    // Lines to the port
    output var laser_port_pkg::hw_in_t pins
);
    import laser_port_pkg::*;

    int hold_cnt;

    initial
    begin
        pins = '0;
        hold_cnt = 0;
    end

    // ------------------------------------------------------------------
    // Line drive
    // ------------------------------------------------------------------
    // HOLD is kept short in the bench; a real controller needs 1 ms.
    always @(posedge ref_clk)
    begin
        pins <= want;
        if (status.program_running_out && pins.start_execute_in)
            pins.start_execute_in <= 1'b1;
        if (want.program_select_in != PROG_NONE)
            pins.analog_enable_in <= 1'b0;
        if (hold_cnt != 0)
        begin
            pins.alarm_reset_in <= 1'b1;
            hold_cnt <= hold_cnt - 1;
        end
        else if (want.alarm_reset_in && !pins.alarm_reset_in)
            hold_cnt <= HOLD;
    end

endmodule

`default_nettype wire

// file: test_hardwired_remote_control_port.sv
/*
 * Self-checking bench of the remote control port with a controller model.
 * Assumes the design answers pin changes within a few clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module test_hardwired_remote_control_port;
    import laser_port_pkg::*;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    hw_in_t cmd = '0;
    hw_in_t pins;
    hw_out_t po;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic ack;
    logic [31:0] rd;
    int fails = 0;
    int comparisons = 0;
    int exp_gate = 0;
    int codes[$] = '{1, 2, 3, 5, 0};
    logic [6:0] sel;

    always #12.5 ref_clk = ~ref_clk;

    laser_remote_port u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .pins_in(pins),
        .pins_out(po), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack));

    plc_model #(.HOLD(40)) u_plc (
        .ref_clk(ref_clk), .status(po), .want(cmd), .pins(pins));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task settle;
        repeat (6) @(posedge ref_clk);
    endtask

    // Holds the request until ack is sampled, so no edge can be missed.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            print_verdict;
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(39241));
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk("outs", 32'h0, 32'(po));
        wb(1'b0, ADR_CTRL, 32'h0);
        chk("ctrl", 32'(CTRL_RESET), rd);
        @(posedge ref_clk) cmd.guide_light_request_in <= 1'b1;
        settle;
        chk("guide", 32'h0, 32'(po.guide_light_out));
        chk("ack", 32'h0, 32'(po.request_ack_out));
        @(posedge ref_clk) cmd.remote_request_in <= 1'b1;
        settle;
        chk("ack", 32'h1, 32'(po.request_ack_out));
        chk("guide", 32'h1, 32'(po.guide_light_out));
        @(posedge ref_clk) cmd.main_power_in <= 1'b1;
        settle;
        chk("power", 32'h1, 32'(po.main_power_on_out));
        foreach (codes[i])
        begin
            @(posedge ref_clk) cmd.gate_select_in <= 4'(codes[i]);
            if (codes[i] <= 3)
                exp_gate = codes[i];
            settle;
            chk("gate", 32'(exp_gate), 32'(po.gate_status_out));
            chk("open", (exp_gate == 0) ? 32'h0 : 32'h1 << (exp_gate - 1),
                32'(po.gate_open_out));
        end
        wb(1'b1, ADR_CTRL, 32'h1);
        settle;
        chk("ready", 32'h1, 32'(po.ready_out));
        $display("test request power gate done");
        @(posedge ref_clk) cmd.start_execute_in <= 1'b1;
        settle;
        chk("emit", 32'h1, 32'(po.emitting_out));
        chk("run", 32'h0, 32'(po.program_running_out));
        @(posedge ref_clk) cmd.start_execute_in <= 1'b0;
        settle;
        chk("emit", 32'h0, 32'(po.emitting_out));
        @(posedge ref_clk) cmd.analog_enable_in <= 1'b1;
        settle;
        chk("analog", 32'h1, 32'(po.analog_mode_out));
        wb(1'b0, ADR_PROG, 32'h0);
        chk("source", 32'h2, 32'(rd[12:11]));
        @(posedge ref_clk) cmd.analog_enable_in <= 1'b0;
        $display("test enable analog done");
        sel = 7'($urandom_range(127, 1));
        @(posedge ref_clk) cmd.program_select_in <= sel;
        settle;
        @(posedge ref_clk) cmd.start_execute_in <= 1'b1;
        settle;
        chk("run", 32'h1, 32'(po.program_running_out));
        wb(1'b0, ADR_PROG, 32'h0);
        chk("prog", 32'(sel), 32'(rd[6:0]));
        chk("source", 32'h1, 32'(rd[12:11]));
        wb(1'b1, ADR_CMD, 32'h4);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk("state", 32'h2, 32'(rd[1:0]));
        @(posedge ref_clk) cmd.sync_in <= 1'b1;
        settle;
        wb(1'b0, ADR_STATUS, 32'h0);
        chk("state", 32'h1, 32'(rd[1:0]));
        @(posedge ref_clk) cmd.sync_in <= 1'b0;
        wb(1'b1, ADR_CMD, 32'h1);
        settle;
        chk("run", 32'h0, 32'(po.program_running_out));
        chk("ended", 32'h1, 32'(po.program_ended_out));
        @(posedge ref_clk) cmd.start_execute_in <= 1'b0;
        settle;
        chk("ended", 32'h0, 32'(po.program_ended_out));
        $display("test program run done");
        @(posedge ref_clk) cmd.start_execute_in <= 1'b1;
        settle;
        @(posedge ref_clk) cmd.program_stop_in <= 1'b1;
        settle;
        chk("run", 32'h0, 32'(po.program_running_out));
        chk("abort", 32'h1, 32'(po.abnormal_end_out));
        @(posedge ref_clk) cmd <= '{remote_request_in: 1'b1,
            main_power_in: 1'b1, alarm_reset_in: 1'b1, default: 1'b0};
        repeat (50) @(posedge ref_clk);
        chk("abort", 32'h0, 32'(po.abnormal_end_out));
        @(posedge ref_clk) cmd.alarm_reset_in <= 1'b0;
        $display("test program abort done");
        @(posedge ref_clk) cmd.program_select_in <= sel;
        settle;
        @(posedge ref_clk) cmd.start_execute_in <= 1'b1;
        settle;
        chk("run", 32'h1, 32'(po.program_running_out));
        wb(1'b1, ADR_CMD, 32'h2);
        settle;
        chk("run", 32'h0, 32'(po.program_running_out));
        chk("abort", 32'h1, 32'(po.abnormal_end_out));
        $display("test program fail done");
        wb(1'b1, ADR_CTRL, 32'h7);
        settle;
        chk("fault", 32'h1, 32'(po.fault_out));
        chk("warn", 32'h1, 32'(po.warning_out));
        chk("ready", 32'h0, 32'(po.ready_out));
        wb(1'b1, ADR_CTRL, 32'h1);
        settle;
        chk("fault", 32'h1, 32'(po.fault_out));
        chk("warn", 32'h0, 32'(po.warning_out));
        @(posedge ref_clk) cmd.alarm_reset_in <= 1'b1;
        repeat (50) @(posedge ref_clk);
        chk("fault", 32'h0, 32'(po.fault_out));
        chk("abort", 32'h0, 32'(po.abnormal_end_out));
        @(posedge ref_clk) cmd.internal_control_enable_in <= 1'b1;
        settle;
        chk("internal", 32'h1, 32'(po.internal_mode_out));
        wb(1'b1, ADR_CTRL, 32'h9);
        settle;
        chk("emit", 32'h1, 32'(po.emitting_out));
        wb(1'b1, ADR_CTRL, 32'h1);
        settle;
        chk("emit", 32'h0, 32'(po.emitting_out));
        wb(1'b1, 8'h10, 32'hff);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        @(posedge ref_clk) cmd.main_power_in <= 1'b0;
        settle;
        chk("power", 32'h0, 32'(po.main_power_on_out));
        @(posedge ref_clk) cmd.remote_request_in <= 1'b0;
        settle;
        chk("ack", 32'h0, 32'(po.request_ack_out));
        @(posedge ref_clk) sys_rst <= 1'b1;
        @(posedge ref_clk) sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk("outs", 32'h0, 32'(po));
        $display("test fault internal reset done");
        print_verdict;
    end

endmodule

`default_nettype wire
